/* rtl/sbs_pkg.sv */
// constants of the sweep and burst sequencer
// assumes a 16-bit word port and a 10-bit converter data path
package sbs_pkg;
   // word address field and register codes
   localparam int ADDR_HI = 15;
   localparam int ADDR_LO = 14;
   localparam logic [1:0] ADDR_INTERVAL = 2'h1;
   localparam logic [1:0] ADDR_BURST = 2'h2;
   // timing word fields
   localparam int UNIT_BIT = 13;
   localparam int MULT_HI = 12;
   localparam int MULT_LO = 11;
   localparam int LEN_W = 11;
   // control word bits
   localparam int CTL_DAC_EN = 10;
   localparam int CTL_SINE = 9;
   localparam int CTL_SQ_EN = 8;
   localparam int CTL_CONT = 7;
   localparam int CTL_GATE_EXT = 6;
   localparam int CTL_STEP_EXT = 5;
   localparam int CTL_MARK_SEL = 3;
   localparam int CTL_MARK_EN = 2;
   // multiplier codes and factors
   localparam logic [1:0] MULT_X5 = 2'h1;
   localparam logic [1:0] MULT_X100 = 2'h2;
   localparam logic [1:0] MULT_X500 = 2'h3;
   localparam logic [8:0] FACT_1 = 9'h001;
   localparam logic [8:0] FACT_5 = 9'h005;
   localparam logic [8:0] FACT_100 = 9'h064;
   localparam logic [8:0] FACT_500 = 9'h1F4;
   // converter data
   localparam int DAC_W = 10;
   localparam logic [9:0] MIDSCALE = 10'h200;
   // marker pulse length in clock periods
   localparam logic [2:0] MARK_PULSE = 3'h4;
   typedef enum logic [1:0] {
      SBS_IDLE = 2'b00,
      SBS_BURST = 2'b01,
      SBS_LISTEN = 2'b10,
      SBS_DONE = 2'b11
   } sbs_state_t;
endpackage : sbs_pkg

/* rtl/sbs_timer_if.sv */
// carrier between the sequencer and one interval timer
// assumes both ends share the sequencer clock
`timescale 1ns/10ps
`default_nettype none
interface sbs_timer_if;
   logic restart;
   logic hold;
   logic unit_waves;
   logic [1:0] mult;
   logic [10:0] length;
   logic wave_tick;
   logic expired;
   modport ctl (output restart, hold, unit_waves, mult, length, wave_tick, input expired);
   modport tmr (input restart, hold, unit_waves, mult, length, wave_tick, output expired);
endinterface : sbs_timer_if
`default_nettype wire

/* rtl/sbs_timer.sv */
// base interval timer: counts length base intervals
// assumes restart is a one-cycle pulse from the sequencer
`timescale 1ns/10ps
`default_nettype none
module sbs_timer (
   input wire logic i_clk,
   input wire logic i_rst_b,
   sbs_timer_if.tmr tif
);
   logic [8:0] pre_reg;
   logic [10:0] cnt_reg;
   logic exp_reg;
   logic [8:0] fact;
   logic tick;
   logic pre_wrap;
   // ----------------------------------------
   // prescale factor and base tick
   // ----------------------------------------
   assign fact = (tif.mult == sbs_pkg::MULT_X5) ? sbs_pkg::FACT_5 :
                 (tif.mult == sbs_pkg::MULT_X100) ? sbs_pkg::FACT_100 :
                 (tif.mult == sbs_pkg::MULT_X500) ? sbs_pkg::FACT_500 : sbs_pkg::FACT_1;
   assign tick = tif.unit_waves ? tif.wave_tick : 1'b1; // cycles or clock periods
   assign pre_wrap = (pre_reg >= fact - sbs_pkg::FACT_1);
   assign tif.expired = exp_reg;
   // count prescaled ticks; frozen while held for standby
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pre_reg <= 9'h000;
         cnt_reg <= 11'h000;
         exp_reg <= 1'b0;
      end else if (tif.restart) begin
         pre_reg <= 9'h000;
         cnt_reg <= 11'h000;
         exp_reg <= 1'b0;
      end else if (!tif.hold && !exp_reg && tick) begin
         pre_reg <= pre_wrap ? 9'h000 : pre_reg + 9'h001;
         if (pre_wrap) begin
            cnt_reg <= cnt_reg + 11'h001;
            exp_reg <= (cnt_reg + 11'h001 >= tif.length);
         end
      end
   end
endmodule : sbs_timer
`default_nettype wire

/* rtl/sbs_sequencer.sv */
// sweep and burst sequencer of a frequency-sweep waveform generator
// assumes trigger, abort and standby come from pins of another domain;
// timing and control words arrive already assembled on word ports
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - burst word: 11-bit duration, D13 picks waveform cycles or clocks
// - unit bits disagree: the interval word's unit wins, except with external increment
// - multiplier from the interval word, except with external increment
// - rising trigger starts the sweep at the start frequency
// - each increment adds the step, for step_count increments
// - auto mode: burst for burst duration, midscale rest of interval
// - external increment: first edge starts, later edges step
// - external increment: burst, then midscale until next trigger
// - external increment: unit and multiplier from burst word
// - fully external: output while trigger high, midscale while low
// - fully external: unit and multiplier bits ignored
// - abort rising edge, sampled, resets state and forces midscale
// - standby high freezes accumulator and holds the output
// - standby low resumes the sweep where it paused
// - D9 set gives parabolic sine, clear gives 10-bit triangle
// - D8 drives square pin with inverted converter data msb
// - D2 enables marker; D3 picks end-of-sweep or 4-clock pulse
// - multiplier codes scale base interval by 1, 5, 100, 500
// - step k outputs start plus k times the signed step
module sbs_sequencer #(
   parameter int FREQ_W = 24,
   parameter int COUNT_W = 12
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [15:0] i_word,
   input wire logic i_word_load,
   input wire logic [15:0] i_ctrl_word,
   input wire logic i_ctrl_load,
   input wire logic [FREQ_W-1:0] i_start_frequency,
   input wire logic [FREQ_W-1:0] i_step_value,
   input wire logic [COUNT_W-1:0] i_step_count,
   input wire logic i_trigger,
   input wire logic i_abort,
   input wire logic i_standby,
   output logic [9:0] o_dac_data,
   output logic o_converter_enable,
   output logic o_square_out_pin,
   output logic o_sweep_marker_pin,
   output logic o_sweep_busy
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [15:0] interval_reg;
   logic [15:0] burst_reg;
   logic [15:0] ctrl_reg;
   sbs_pkg::sbs_state_t state_reg;
   sbs_pkg::sbs_state_t state_next;
   logic [FREQ_W-1:0] freq_reg;
   logic [FREQ_W-1:0] freq_next;
   logic [COUNT_W-1:0] index_reg;
   logic [COUNT_W-1:0] index_next;
   logic [FREQ_W-1:0] phase_reg;
   logic phase_msb_reg;
   logic [2:0] mark_cnt_reg;
   logic [2:0] mark_cnt_next;
   logic [9:0] dac_reg;
   logic [9:0] dac_next;
   logic square_reg;
   logic marker_reg;
   logic busy_reg;
   logic dac_en_reg;
   // pin synchronisers: three stages, level moves when 2 and 3 agree
   logic [2:0] trig_sync_reg;
   logic [2:0] abort_sync_reg;
   logic [2:0] stby_sync_reg;
   logic trig_lvl_reg;
   logic trig_prev_reg;
   logic abort_lvl_reg;
   logic abort_prev_reg;
   logic stby_lvl_reg;

   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   logic cont_mode;
   logic gate_ext;
   logic step_ext;
   logic full_ext;
   logic ext_inc;
   logic trig_rise;
   logic trig_fall;
   logic abort_rise;
   logic standby;
   logic in_sweep;

   assign cont_mode = ctrl_reg[sbs_pkg::CTL_CONT];
   assign gate_ext = ctrl_reg[sbs_pkg::CTL_GATE_EXT];
   assign step_ext = ctrl_reg[sbs_pkg::CTL_STEP_EXT];
   assign full_ext = gate_ext & step_ext;
   assign ext_inc = step_ext & ~gate_ext;
   // edges come from the filtered level only
   assign trig_rise = trig_lvl_reg & ~trig_prev_reg;
   assign trig_fall = ~trig_lvl_reg & trig_prev_reg;
   assign abort_rise = abort_lvl_reg & ~abort_prev_reg;
   assign standby = stby_lvl_reg;
   assign in_sweep = (state_reg == sbs_pkg::SBS_BURST) ||
                     (state_reg == sbs_pkg::SBS_LISTEN);

   // ----------------------------------------
   // interval and burst timers
   // ----------------------------------------
   sbs_timer_if int_if ();
   sbs_timer_if bst_if ();
   logic wave_tick;
   logic timers_restart;

   // one output waveform cycle counted at each rise of the accumulator msb
   assign wave_tick = phase_reg[FREQ_W-1] & ~phase_msb_reg;

   // interval timer always uses the interval word's settings
   assign int_if.restart = timers_restart;
   assign int_if.hold = standby;
   assign int_if.unit_waves = ~interval_reg[sbs_pkg::UNIT_BIT];
   assign int_if.mult = interval_reg[sbs_pkg::MULT_HI:sbs_pkg::MULT_LO];
   assign int_if.length = interval_reg[sbs_pkg::LEN_W-1:0];
   assign int_if.wave_tick = wave_tick;

   // burst timer: unit and multiplier taken from the interval word,
   // except with external increment, where the burst word rules
   assign bst_if.restart = timers_restart;
   assign bst_if.hold = standby;
   assign bst_if.unit_waves = ext_inc ? ~burst_reg[sbs_pkg::UNIT_BIT] :
                              ~interval_reg[sbs_pkg::UNIT_BIT];
   assign bst_if.mult = ext_inc ? burst_reg[sbs_pkg::MULT_HI:sbs_pkg::MULT_LO] :
                        interval_reg[sbs_pkg::MULT_HI:sbs_pkg::MULT_LO];
   assign bst_if.length = burst_reg[sbs_pkg::LEN_W-1:0];
   assign bst_if.wave_tick = wave_tick;

   sbs_timer u_int_timer (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .tif(int_if)
   );

   sbs_timer u_bst_timer (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .tif(bst_if)
   );

   // ----------------------------------------
   // sweep events
   // ----------------------------------------
   logic start_evt;
   logic adv_evt;
   logic burst_end;
   logic last_step;

   // a rising trigger starts from idle or restarts a finished sweep
   assign start_evt = trig_rise && !in_sweep;
   // the fully external mode never consults the timers
   assign adv_evt = in_sweep && (step_ext ? trig_rise : int_if.expired);
   assign burst_end = (state_reg == sbs_pkg::SBS_BURST) && !cont_mode &&
                      (full_ext ? trig_fall : bst_if.expired);
   assign last_step = (index_reg == i_step_count);
   assign timers_restart = !standby && !abort_rise && (start_evt || adv_evt);

   // next state, frequency and step index
   always_comb begin
      state_next = state_reg;
      freq_next = freq_reg;
      index_next = index_reg;
      mark_cnt_next = (mark_cnt_reg != 3'h0) ? mark_cnt_reg - 3'h1 : 3'h0;
      if (start_evt) begin
         state_next = sbs_pkg::SBS_BURST;
         freq_next = i_start_frequency;
         index_next = '0;
      end else if (adv_evt) begin
         if (last_step) begin
            state_next = sbs_pkg::SBS_DONE;
         end else begin
            state_next = sbs_pkg::SBS_BURST;
            freq_next = freq_reg + i_step_value;
            index_next = index_reg + {{(COUNT_W-1){1'b0}}, 1'b1};
            mark_cnt_next = sbs_pkg::MARK_PULSE;
         end
      end else if (burst_end) begin
         state_next = sbs_pkg::SBS_LISTEN;
      end
   end

   // ----------------------------------------
   // waveform shaping
   // ----------------------------------------
   logic [9:0] phase_top;
   logic [9:0] tri_wave;
   logic [8:0] half_x;
   logic [17:0] sine_prod;
   logic [9:0] sine_wave;
   logic [9:0] wave;

   assign phase_top = phase_reg[FREQ_W-1 -: sbs_pkg::DAC_W];
   // truncated phase folded into a linear triangle
   assign tri_wave = phase_top[9] ? ~{phase_top[8:0], 1'b0} : {phase_top[8:0], 1'b0};
   // parabolic sine: cheap, no lookup memory, up to roughly 28 lsb off
   assign half_x = phase_top[8:0];
   assign sine_prod = half_x * (9'h1FF - half_x);
   assign sine_wave = phase_top[9] ? sbs_pkg::MIDSCALE - {1'b0, sine_prod[15:7]} :
                      sbs_pkg::MIDSCALE + {1'b0, sine_prod[15:7]};
   assign wave = ctrl_reg[sbs_pkg::CTL_SINE] ? sine_wave : tri_wave;
   // midscale when idle or listening; done keeps the final tone
   assign dac_next = (state_reg == sbs_pkg::SBS_BURST ||
                      state_reg == sbs_pkg::SBS_DONE) ? wave :
                     sbs_pkg::MIDSCALE;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         trig_sync_reg <= 3'h0;
         abort_sync_reg <= 3'h0;
         stby_sync_reg <= 3'h0;
      end else begin
         trig_sync_reg <= {trig_sync_reg[1:0], i_trigger};
         abort_sync_reg <= {abort_sync_reg[1:0], i_abort};
         stby_sync_reg <= {stby_sync_reg[1:0], i_standby};
      end
   end

   // filtered levels and their previous values for edge detection
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         trig_lvl_reg <= 1'b0;
         trig_prev_reg <= 1'b0;
         abort_lvl_reg <= 1'b0;
         abort_prev_reg <= 1'b0;
         stby_lvl_reg <= 1'b0;
      end else begin
         if (trig_sync_reg[1] == trig_sync_reg[2]) trig_lvl_reg <= trig_sync_reg[2];
         if (abort_sync_reg[1] == abort_sync_reg[2]) abort_lvl_reg <= abort_sync_reg[2];
         if (stby_sync_reg[1] == stby_sync_reg[2]) stby_lvl_reg <= stby_sync_reg[2];
         // the trigger edge is held back in standby so it is not lost
         if (!standby) trig_prev_reg <= trig_lvl_reg;
         abort_prev_reg <= abort_lvl_reg;
      end
   end

   // ----------------------------------------
   // word ports
   // ----------------------------------------
   logic ld_interval;
   logic ld_burst;
   assign ld_interval = i_word_load &&
                        (i_word[sbs_pkg::ADDR_HI:sbs_pkg::ADDR_LO] == sbs_pkg::ADDR_INTERVAL);
   assign ld_burst = i_word_load &&
                     (i_word[sbs_pkg::ADDR_HI:sbs_pkg::ADDR_LO] == sbs_pkg::ADDR_BURST);

   // other word codes belong to registers outside this block
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         interval_reg <= 16'h0000;
         burst_reg <= 16'h0000;
         ctrl_reg <= 16'h0000;
      end else begin
         if (ld_interval) interval_reg <= i_word;
         if (ld_burst) burst_reg <= i_word;
         if (i_ctrl_load) ctrl_reg <= i_ctrl_word;
      end
   end

   // ----------------------------------------
   // sweep state
   // ----------------------------------------
   // abort wins over everything; standby freezes all sweep state
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg <= sbs_pkg::SBS_IDLE;
         freq_reg <= '0;
         index_reg <= '0;
         mark_cnt_reg <= 3'h0;
      end else if (abort_rise) begin
         state_reg <= sbs_pkg::SBS_IDLE;
         index_reg <= '0;
         mark_cnt_reg <= 3'h0;
      end else if (!standby) begin
         state_reg <= state_next;
         freq_reg <= freq_next;
         index_reg <= index_next;
         mark_cnt_reg <= mark_cnt_next;
      end
   end

   // phase accumulator stops in standby, so the output holds
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         phase_reg <= '0;
         phase_msb_reg <= 1'b0;
      end else if (!standby) begin
         phase_reg <= phase_reg + freq_reg;
         phase_msb_reg <= phase_reg[FREQ_W-1];
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dac_reg <= sbs_pkg::MIDSCALE;
         square_reg <= 1'b0;
         marker_reg <= 1'b0;
         busy_reg <= 1'b0;
         dac_en_reg <= 1'b0;
      end else begin
         dac_en_reg <= ctrl_reg[sbs_pkg::CTL_DAC_EN];
         if (abort_rise) begin
            dac_reg <= sbs_pkg::MIDSCALE;
         end else if (!standby) begin
            dac_reg <= dac_next;
         end
         square_reg <= ctrl_reg[sbs_pkg::CTL_SQ_EN] & ~dac_reg[9];
         marker_reg <= ctrl_reg[sbs_pkg::CTL_MARK_EN] &
                       (ctrl_reg[sbs_pkg::CTL_MARK_SEL] ? (mark_cnt_reg != 3'h0) :
                        (state_reg == sbs_pkg::SBS_DONE));
         busy_reg <= in_sweep;
      end
   end

   assign o_dac_data = dac_reg;
   assign o_converter_enable = dac_en_reg;
   assign o_square_out_pin = square_reg;
   assign o_sweep_marker_pin = marker_reg;
   assign o_sweep_busy = busy_reg;
endmodule : sbs_sequencer
`default_nettype wire

/* test/sbs_sequencer_chk.sv */
// port checker of the sweep sequencer
// assumes one clock and the bind after the module
`timescale 1ns/10ps
`default_nettype none
module sbs_chk (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [15:0] i_ctrl_word,
   input wire logic i_ctrl_load,
   input wire logic i_trigger,
   input wire logic i_abort,
   input wire logic i_standby,
   input wire logic [9:0] o_dac_data,
   input wire logic o_converter_enable,
   input wire logic o_square_out_pin,
   input wire logic o_sweep_marker_pin,
   input wire logic o_sweep_busy
);
   // --------------
   // control shadow
   // --------------
   logic [15:0] ctl_reg;
   logic [1:0] ld_reg;
   logic quiet, msb, mark_en, pulse_mode, end_mode;
   // checks wait two quiet cycles so the shadow never races the design
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctl_reg <= 16'h0000;
         ld_reg <= 2'h0;
      end else begin
         ld_reg <= {ld_reg[0], i_ctrl_load};
         ctl_reg <= i_ctrl_load ? i_ctrl_word : ctl_reg;
      end
   end
   // decoded views of the shadow
   assign quiet = !i_ctrl_load && (ld_reg == 2'h0);
   assign msb = o_dac_data[9];
   assign mark_en = quiet && ctl_reg[sbs_pkg::CTL_MARK_EN];
   assign pulse_mode = mark_en && ctl_reg[sbs_pkg::CTL_MARK_SEL];
   assign end_mode = mark_en && !ctl_reg[sbs_pkg::CTL_MARK_SEL];
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   sequence s_pulse4;
      o_sweep_marker_pin [*4] ##1 !o_sweep_marker_pin;
   endsequence
   property p_conv;
      logic v;
      (i_ctrl_load, v = i_ctrl_word[sbs_pkg::CTL_DAC_EN]) ##1 !i_ctrl_load
         |=> o_converter_enable == v;
   endproperty
   a_conv_copy: assert property (p_conv)
      else $error("converter enable mismatch");
   a_square_msb: assert property (quiet |->
      o_square_out_pin == (ctl_reg[sbs_pkg::CTL_SQ_EN] & ~$past(msb)))
      else $error("square pin mismatch");
   a_marker_off: assert property (quiet && !mark_en |-> !o_sweep_marker_pin)
      else $error("marker active while disabled");
   a_pulse_len: assert property ($rose(o_sweep_marker_pin) && pulse_mode |-> s_pulse4)
      else $error("marker pulse length wrong");
   a_end_level: assert property ($fell(o_sweep_busy) && end_mode |->
      ##[0:2] o_sweep_marker_pin) else $error("end marker missing");
   a_start_busy: assert property ($rose(i_trigger) && !o_sweep_busy && !i_abort
      && !i_standby |-> ##[2:10] o_sweep_busy) else $error("sweep did not start");
   a_standby_hold: assert property (i_standby [*8] |-> $stable(o_dac_data))
      else $error("output moved in standby");
   a_abort_mid: assert property ((i_abort && !i_trigger && !i_standby) [*8] |->
      o_dac_data == sbs_pkg::MIDSCALE && !o_sweep_busy) else $error("abort ignored");
endmodule : sbs_chk
bind sbs_sequencer sbs_chk u_sbs_chk (.i_clk, .i_rst_b, .i_ctrl_word, .i_ctrl_load,
   .i_trigger, .i_abort, .i_standby, .o_dac_data, .o_converter_enable,
   .o_square_out_pin, .o_sweep_marker_pin, .o_sweep_busy);
`default_nettype wire

/* test/sbs_host_model.sv */
// host model that drives the sweep trigger pin
// assumes a one-cycle fire strobe from the bench
`timescale 1ns/10ps
`default_nettype none
module sbs_host_model (
   input wire logic i_clk,
   input wire logic i_fire,
   input wire logic [11:0] i_high,
   output logic o_trigger,
   output logic o_idle
);
   // ------------
   // pulse shaper
   // ------------
   logic [12:0] left_reg = 13'h0000;
   // high for i_high cycles, then low as long so edges stay well apart
   always @(posedge i_clk) begin
      if (i_fire && left_reg == 13'h0000) begin
         left_reg <= {i_high, 1'b0};
      end else if (left_reg != 13'h0000) begin
         left_reg <= left_reg - 13'h0001;
      end
   end
   assign o_trigger = left_reg > {1'b0, i_high};
   assign o_idle = left_reg == 13'h0000;
endmodule : sbs_host_model
`default_nettype wire

/* test/tb_sbs_sequencer.sv */
// bench for the sweep and burst sequencer
// assumes the checker is bound in and the host model owns the trigger
`timescale 1ns/10ps
`default_nettype none
module tb_sbs_sequencer;
   logic i_clk = 1'b0, i_rst_b = 1'b0, i_word_load = 1'b0, i_ctrl_load = 1'b0;
   logic i_abort = 1'b0, i_standby = 1'b0, fire = 1'b0;
   logic [15:0] i_word = 16'h0000, i_ctrl_word = 16'h0000;
   logic [11:0] high_len = 12'h008;
   logic i_trigger, idle, o_converter_enable, o_square_out_pin, o_sweep_marker_pin;
   logic o_sweep_busy;
   logic [9:0] o_dac_data;
   int bad_count = 0, samples_checked = 0, cycles = 0, n, f;
   int fct [4] = '{1, 5, 100, 500};
   // control words beside the converter enable they give
   logic [16:0] rows [6] = '{17'h10400, 17'h00000, 17'h10620, 17'h00060, 17'h00080,
      17'h10440};
   // -------------------
   // design and partner
   // -------------------
   sbs_sequencer u_sbs_sequencer (.i_clk, .i_rst_b, .i_word, .i_word_load, .i_ctrl_word,
      .i_ctrl_load, .i_start_frequency(24'h100000), .i_step_value(24'h010000),
      .i_step_count(12'h002), .i_trigger, .i_abort, .i_standby, .o_dac_data,
      .o_converter_enable, .o_square_out_pin, .o_sweep_marker_pin, .o_sweep_busy);
   sbs_host_model u_sbs_host_model (.i_clk, .i_fire(fire), .i_high(high_len),
      .o_trigger(i_trigger), .o_idle(idle));
   // clock, and a ceiling well above the longest expected run
   always #50 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         results();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic results();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results
   // one word on either strobe; the strobe drops on the following edge
   task automatic put(input logic c, input logic [15:0] w);
      @(posedge i_clk);
      i_ctrl_word <= c ? w : i_ctrl_word;
      i_word <= c ? i_word : w;
      i_ctrl_load <= c;
      i_word_load <= !c;
      @(posedge i_clk);
      i_ctrl_load <= 1'b0;
      i_word_load <= 1'b0;
   endtask : put
   task automatic pulse(input logic [11:0] h, input logic w);
      @(posedge i_clk);
      high_len <= h;
      fire <= 1'b1;
      @(posedge i_clk);
      fire <= 1'b0;
      @(posedge i_clk);
      while (w && idle !== 1'b1) @(posedge i_clk);
      @(negedge i_clk);
   endtask : pulse
   // busy length of one auto sweep; sb opens a 100-cycle standby window
   task automatic run(input int fa, input int sb, output int k);
      pulse(12'h008, 1'b0);
      k = 0;
      while (o_sweep_busy !== 1'b1) @(negedge i_clk);
      while (o_sweep_busy === 1'b1) begin
         @(posedge i_clk);
         i_standby <= (k + 1 == sb) ? 1'b1 : (k + 1 == sb + 100) ? 1'b0 : i_standby;
         @(negedge i_clk);
         k++;
         if (k == 3 * fa && fa > 1 && sb == 0) chk(o_dac_data, sbs_pkg::MIDSCALE);
         if (k == 3 && fa == 1) chk(o_dac_data != sbs_pkg::MIDSCALE, 1'b1);
      end
   endtask : run
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (5) @(posedge i_clk);
      @(negedge i_clk);
      chk({o_dac_data, o_converter_enable, o_square_out_pin, o_sweep_marker_pin,
         o_sweep_busy}, {sbs_pkg::MIDSCALE, 4'h0});
      // every mode code and continuous output, then enable readback
      foreach (rows[i]) begin
         put(1'b1, rows[i][15:0]);
         @(negedge i_clk);
         @(negedge i_clk);
         chk(o_converter_enable, rows[i][16]);
      end
      // auto sweeps over every multiplier; burst word unit always disagrees, its multiplier in the first three;
      // the first sweep is continuous sine, so it never rests at midscale
      for (int m = 0; m < 4; m++) begin
         f = fct[m];
         put(1'b1, {m == 0 ? 12'h078 : 12'h050, m[0], 3'h4});
         put(1'b0, {2'h1, 1'b1, m[1:0], 11'h004});
         put(1'b0, 16'h9802);
         put(1'b0, 16'hFFFF);
         put(1'b0, 16'h3FFF);
         run(f, m == 2 ? 40 : 0, n);
         f = 12 * f + (m == 2 ? 100 : 0);
         chk(n >= f - 6 && n <= f + 6, 1'b1);
         repeat (3) @(negedge i_clk);
         chk(o_sweep_marker_pin, !m[0]);
      end
      // external increment, timing from the burst word
      put(1'b1, 16'h0524);
      put(1'b0, 16'h7804);
      put(1'b0, 16'hA002);
      pulse(12'h014, 1'b1);
      chk({o_dac_data, o_sweep_busy}, {sbs_pkg::MIDSCALE, 1'b1});
      repeat (2) pulse(12'h014, 1'b1);
      chk(o_sweep_busy, 1'b1);
      pulse(12'h014, 1'b1);
      chk(o_sweep_busy, 1'b0);
      // fully external: midscale in the low part of the trigger
      put(1'b1, 16'h0564);
      pulse(12'h014, 1'b1);
      chk({o_dac_data, o_sweep_busy}, {sbs_pkg::MIDSCALE, 1'b1});
      // abort in mid-sweep with the marker off
      put(1'b1, 16'h0400);
      @(posedge i_clk);
      i_abort <= 1'b1;
      repeat (8) @(posedge i_clk);
      i_abort <= 1'b0;
      repeat (4) @(negedge i_clk);
      chk({o_dac_data, o_sweep_busy}, {sbs_pkg::MIDSCALE, 1'b0});
      results();
   end
endmodule : tb_sbs_sequencer
`default_nettype wire
